//--- core/iprt_readout.v
`timescale 1ns/100ps
`include "iprt_consts.vh"
module iprt_readout (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_out,
  input wire [1:0] status_in,
  input wire [13:0] pressure_in,
  input wire [10:0] temperature_in,
  output reg busy_out
);
  // ***************
  // sampling
  // ***************
  wire scl_s;
  wire sda_s;
  reg scl_q;
  reg sda_q;
  iprt_sync u_scl (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in(scl_in),
    .q_out(scl_s)
  );
  iprt_sync u_sda (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in(sda_in),
    .q_out(sda_s)
  );
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  // ***************
  // bus events
  // ***************
  // no glitch filter: a spike on scl reads as a bit
  // a stop anywhere ends the frame; a repeated start restarts it
  // host owns the clock; we only look for its edges
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  // ***************
  // state machine
  // ***************
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_SEND = 3'd3;
  localparam ST_MACK = 3'd4;
  reg [2:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg [1:0] byte_q;
  reg [31:0] frame_q;
  reg drive_low_q;
  // pack the reading; temperature low bits sit at the top of byte four
  function [31:0] pack;
    input [1:0] st;
    input [13:0] pr;
    input [10:0] tp;
    begin
      pack = {st, pr[13:8], pr[7:0], tp[10:3], tp[2:0], 5'h00};
    end
  endfunction
  function [7:0] pick;
    input [31:0] fr;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: pick = fr[31:24];
        2'd1: pick = fr[23:16];
        2'd2: pick = fr[15:8];
        default: pick = fr[7:0];
      endcase
    end
  endfunction
  // ***************
  // pin drive
  // ***************
  // open-drain: only ever low or released
  assign sda_out = 1'b0;
  // the enable follows the flop with no extra stage, so data moves a
  // full clock before the host can raise scl again
  always @* begin
    sda_oe_out = drive_low_q;
  end
  // ***************
  // address capture
  // ***************
  // counts rises only while addressing; a start clears it
  reg [3:0] abit_q;
  reg [7:0] addr_q;
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      abit_q <= 4'h0;
      addr_q <= 8'h00;
    end else if (start_cond) begin
      abit_q <= 4'h0;
      addr_q <= 8'h00;
    end else if (state_q == ST_ADDR && scl_rise) begin
      abit_q <= abit_q + 4'h1;
      addr_q <= {addr_q[6:0], sda_s};
    end
  end
  wire addr_end = (state_q == ST_ADDR) && scl_fall &&
    (abit_q == `IPRT_ADDR_BITS);
  // address plus read bit; a write is never answered
  wire addr_hit = addr_end &&
    (addr_q == {`IPRT_TARGET_ADDR, 1'b1});
  // ***************
  // reading capture
  // ***************
  // latched once at the match so all four bytes come from one sample
  // the inputs must be steady at the match; later changes wait a frame
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_q <= 32'h0000_0000;
    end else if (addr_hit) begin
      frame_q <= pack(status_in, pressure_in, temperature_in);
    end
  end
  // ***************
  // byte select
  // ***************
  // the next byte is chosen at the ack rise, ahead of its first bit
  wire [7:0] first_byte = pick(frame_q, 2'd0);
  wire [1:0] byte_nx = byte_q + 2'd1;
  wire [7:0] next_byte = pick(frame_q, byte_nx);
  // ***************
  // sequencer
  // ***************
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      bit_q <= 3'd0;
      shift_q <= 8'h00;
      byte_q <= 2'd0;
      drive_low_q <= 1'b0;
      busy_out <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
      drive_low_q <= 1'b0;
      busy_out <= 1'b0;
    end else if (start_cond) begin
      // repeated start also lands here
      state_q <= ST_ADDR;
      bit_q <= 3'd0;
      drive_low_q <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          drive_low_q <= 1'b0;
        end
        ST_ADDR: begin
          if (addr_end) begin
            if (addr_hit) begin
              drive_low_q <= 1'b1;
              state_q <= ST_AACK;
              busy_out <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            byte_q <= 2'd0;
            bit_q <= 3'd1;
            shift_q <= {first_byte[6:0], 1'b0};
            drive_low_q <= ~first_byte[7];
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_q == 3'd0) begin
              drive_low_q <= 1'b0;
              state_q <= ST_MACK;
            end else begin
              drive_low_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q <= bit_q + 3'd1;
            end
          end
        end
        ST_MACK: begin
          // four bytes then release; host nack ends early
          // ack is read on the rise, well after the host set it
          if (scl_rise) begin
            if (sda_s || byte_q == 2'd3) begin
              state_q <= ST_IDLE;
              busy_out <= 1'b0;
            end else begin
              byte_q <= byte_q + 2'd1;
              shift_q <= next_byte;
            end
          end
          if (scl_fall) begin
            bit_q <= 3'd1;
            drive_low_q <= ~shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
            state_q <= ST_SEND;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // iprt_readout

//--- pkg/iprt_consts.vh
`ifndef IPRT_CONSTS_VH
`define IPRT_CONSTS_VH
`define IPRT_TARGET_ADDR 7'h78
`define IPRT_NUM_BYTES 3'h4
`define IPRT_ADDR_BITS 4'h8
`define IPRT_PRES_W 14
`define IPRT_TEMP_W 11
`define IPRT_STAT_W 2
`endif

//--- core/iprt_sync.v
`timescale 1ns/100ps
// two-stage synchroniser for a pin level
module iprt_sync (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire d_in,
  output wire q_out
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule // iprt_sync

//--- tb/iprt_readout_assertions.sv
`timescale 1ns/100ps
module iprt_chk (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire busy_out
);
  // ****
  // pin checks
  // ****
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  property p_low; sda_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("data driven high");
  property p_edge; $changed(sda_oe_out) |-> !scl_in || $past(!scl_in);
  endproperty
  a_edge: assert property (p_edge) else $error("drive moved");
  property p_hi; scl_in && $past(scl_in) && $past(scl_in, 2) |->
    $stable(sda_oe_out); endproperty
  a_hi: assert property (p_hi) else $error("drive moved in high");
  property p_hold; $rose(sda_oe_out) |=> sda_oe_out [*3]; endproperty
  a_hold: assert property (p_hold) else $error("short low bit");
  property p_fell; $fell(busy_out) |-> !sda_oe_out; endproperty
  a_fell: assert property (p_fell) else $error("drive after end");
  property p_start; scl_in && $fell(sda_in) |-> !sda_oe_out; endproperty
  a_start: assert property (p_start) else $error("drive at start");
  property p_stop; scl_in && $rose(sda_in) |-> ##[1:6] !busy_out;
  endproperty
  a_stop: assert property (p_stop) else $error("busy after stop");
  property p_len; $rose(busy_out) |-> ##[1:400] !busy_out; endproperty
  a_len: assert property (p_len) else $error("frame too long");
  c_go: cover property ($rose(busy_out));
  c_end: cover property ($fell(busy_out));
  c_drv: cover property ($rose(sda_oe_out));
endmodule // iprt_chk
bind iprt_readout iprt_chk chk_u (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out));

//--- tb/iprt_host.sv
`timescale 1ns/100ps
module iprt_host (
  input wire clk_sys_in,
  input wire sda_in,
  output logic scl_out,
  output logic sda_low_out,
  output logic seen_out,
  output logic [32:0] got_out
);
  // ****
  // bus host, 800 ns bit
  // ****
  logic r;
  initial {scl_out, sda_low_out, seen_out, got_out} = {3'h4, 33'h0};
  task w(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task bt(input logic b); // host makes clock
    scl_out <= 1'b0;
    w(2);
    sda_low_out <= !b;
    w(2);
    scl_out <= 1'b1;
    w(2);
    r = sda_in;
    w(2);
  endtask
  task rd(input logic [7:0] a); // plain read
    logic [31:0] d;
    logic k;
    sda_low_out <= 1'b1;
    w(4);
    for (int i = 7; i >= 0; i--) bt(a[i]);
    bt(1'b1);
    k = !r;
    d = 32'h0000_0000;
    for (int i = 31; i >= 0 && k; i--) begin
      bt(1'b1);
      d[i] = r;
      if (i % 8 == 0) bt(i == 0);
    end
    scl_out <= 1'b0;
    w(2);
    sda_low_out <= 1'b1;
    w(2);
    scl_out <= 1'b1;
    w(2);
    sda_low_out <= 1'b0; // stop
    w(4);
    got_out <= {k, d};
    seen_out <= 1'b1;
    w(1);
    seen_out <= 1'b0;
  endtask
endmodule // iprt_host

//--- tb/iprt_readout_tb.sv
`timescale 1ns/100ps
module iprt_readout_tb;
  // ****
  // bench
  // ****
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] st = 2'h0;
  logic [13:0] pr = 14'h0000;
  logic [10:0] tp = 11'h000;
  logic [31:0] rs = 32'h7559_9be4;
  logic [32:0] q [$];
  int miscompares = 0;
  int checks = 0;
  wire scl, sda, so, oe, busy, hl, seen;
  wire [32:0] got;
  // pull-up: host low always wins; a stray high drive from the target reads the same as released
  assign sda = hl ? 1'b0 : oe ? so : 1'b1;
  iprt_readout dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_out(oe),
    .status_in(st), .pressure_in(pr), .temperature_in(tp), .busy_out(busy));
  iprt_host host_u (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(hl), .seen_out(seen), .got_out(got));
  function automatic [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task go(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    host_u.rd(a);
  endtask
  initial forever #50 clk_sys_in = !clk_sys_in;
  always @(posedge clk_sys_in) if (seen === 1'b1) begin
    checks++;
    if (got !== q[0]) begin
      $display("[ERR] frame exp %h got %h", q[0], got);
      miscompares++;
    end
    checks++;
    if (busy !== 1'b0) begin
      $display("[ERR] busy exp 0 got %b", busy);
      miscompares++;
    end
    void'(q.pop_front());
  end
  initial begin
    #2000000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 5; i++) begin
      rs = (i == 1) ? 32'hffff_ffff : (i == 2) ? 32'h0000_0000 : lf(rs);
      st <= rs[1:0];
      pr <= rs[15:2];
      tp <= rs[26:16];
      @(posedge clk_sys_in);
      go(8'hf1, {1'b1, rs[1:0], rs[15:2], rs[26:16], 5'h00});
      if (i == 2) rs = 32'h7559_9be4;
    end
    go(8'hf3, 33'h0_0000_0000);
    go(8'hf0, 33'h0_0000_0000);
    stop_test;
  end
endmodule // iprt_readout_tb
